// ==== src/hkm_pkg.sv ====
/*
 * Constants for the housekeeping converter monitor: register addresses,
 * field positions, reset values, mode codes and timing counts.
 * Assumes an 8-bit special-function-register port from the processor core.
 */
package hkm_pkg;
  localparam logic [7:0] ADDR_TEMP_RESULT = 8'hD7;
  localparam logic [7:0] ADDR_MEAS_START = 8'hD8;
  localparam logic [7:0] ADDR_BATT_RESULT = 8'hDF;
  localparam logic [7:0] ADDR_PWR_IRQ_EN = 8'hEC;
  localparam logic [7:0] ADDR_EXT_RESULT = 8'hEF;
  localparam logic [7:0] ADDR_DELTA_CFG = 8'hF3;
  localparam logic [7:0] ADDR_PWR_IRQ_FLAGS = 8'hF8;
  localparam logic [7:0] ADDR_STROBE_PERIOD = 8'hF9;
  localparam logic [7:0] ADDR_BATT_THRESH = 8'hFA;
  // Start bits in measurement_start
  localparam int START_BATT_BIT = 0;
  localparam int START_TEMP_BIT = 1;
  localparam int START_EXT_BIT = 2;
  // Delta fields in change_delta_config
  localparam int DELTA_TEMP_LSB = 0;
  localparam int DELTA_EXT_LSB = 3;
  // Interval fields in background_strobe_period
  localparam int PER_TEMP_LSB = 0;
  localparam int PER_BATT_LSB = 2;
  localparam int PER_EXT_LSB = 4;
  // Flag and enable bit positions in the power interrupt registers
  localparam int FLAG_BATT_BIT = 0;
  localparam int FLAG_EXT_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] DELTA_OFF = 3'h0;
  localparam logic [2:0] DELTA_EVERY = 3'h7;
  localparam logic [1:0] PERIOD_OFF = 2'h0;
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BASE_TICK_US = 1000;
  localparam int BASE_TICK_CYCLES = (CLK_HZ / 1_000_000) * BASE_TICK_US;
  typedef enum logic [1:0] {
    HKM_FULL_POWER_MODE = 2'h0,
    HKM_BATTERY_ACTIVE_MODE = 2'h1,
    HKM_SLEEP_MODE = 2'h2
  } hkm_mode_t;
  typedef enum logic [1:0] {
    HKM_CH_BATT = 2'h0,
    HKM_CH_TEMP = 2'h1,
    HKM_CH_EXT = 2'h2
  } hkm_chan_t;
  typedef enum logic [1:0] {
    HKM_IDLE = 2'b00,
    HKM_CONVERT = 2'b01,
    HKM_DONE = 2'b11
  } hkm_state_t;
endpackage

// ==== src/hkm_monitor.sv ====
/*
 * Housekeeping converter control: one-shot and background conversions of
 * temperature, battery and external DC input, change and threshold checks,
 * result registers and power-management flags.
 * Assumes one shared analog converter reached by a request/channel port that
 * answers with a one-cycle done pulse and a code; register port is the
 * core's synchronous SFR read/write strobes.
 */
`timescale 1ns/1ps
module hkm_monitor #(
  parameter int TICK_CYCLES = hkm_pkg::BASE_TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Power mode
  input wire logic [1:0] i_power_mode,
  // Converter port
  output logic o_conv_req,
  output logic [1:0] o_conv_chan,
  input wire logic i_conv_done,
  input wire logic [7:0] i_conv_code,
  // Interrupts
  output logic o_adc_irq,
  output logic o_power_management_irq
);
  import hkm_pkg::*;

  logic [7:0] temp_result_q, batt_result_q, ext_result_q;
  logic [7:0] temp_last_q, ext_last_q;
  logic [7:0] irq_en_q, delta_cfg_q, strobe_q, thresh_q;
  logic [2:0] start_q;
  logic low_battery_flag_q, ext_change_flag_q;
  logic [2:0] bg_pend_q;
  logic [2:0] tick_div_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  hkm_state_t state_q;
  hkm_chan_t chan_q;
  logic chan_oneshot_q;
  logic [7:0] code_q;

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // 000 never, 111 always, else strictly greater than the code
  function automatic logic delta_hit(input logic [2:0] d, input logic [7:0] diff);
    if (d == DELTA_OFF) delta_hit = 1'b0;
    else if (d == DELTA_EVERY) delta_hit = 1'b1;
    else delta_hit = diff > {5'h00, d};
  endfunction

  // Interval codes 1..3 pick one of three tick taps; 0 is off
  function automatic logic period_hit(input logic [1:0] p, input logic [2:0] div, input logic tk);
    period_hit = tk && (p != PERIOD_OFF) && (div[p - 2'd1] == 1'b0);
  endfunction

  function automatic logic [1:0] pick(input logic [2:0] w);
    if (w[0]) pick = 2'd0;
    else if (w[1]) pick = 2'd1;
    else pick = 2'd2;
  endfunction

  // Interval field of one channel; field order in the register differs from channel order
  function automatic logic [1:0] interval_of(input logic [7:0] s, input int ch);
    if (ch == HKM_CH_BATT) interval_of = s[PER_BATT_LSB +: 2];
    else if (ch == HKM_CH_TEMP) interval_of = s[PER_TEMP_LSB +: 2];
    else interval_of = s[PER_EXT_LSB +: 2];
  endfunction

  wire wr_start = i_reg_wr && (i_reg_addr == ADDR_MEAS_START);
  wire wr_flags = i_reg_wr && (i_reg_addr == ADDR_PWR_IRQ_FLAGS);
  wire sleeping = (i_power_mode == HKM_SLEEP_MODE);
  wire full_power = (i_power_mode == HKM_FULL_POWER_MODE);
  // mode gating for one-shot and background
  wire [2:0] oneshot_ok = sleeping ? 3'b000 : start_q;
  wire [2:0] bg_ok = {~(full_power || sleeping) ? 1'b0 : bg_pend_q[HKM_CH_EXT],
                      ~(full_power || sleeping) ? 1'b0 : bg_pend_q[HKM_CH_TEMP],
                      full_power ? bg_pend_q[HKM_CH_BATT] : 1'b0};
  wire [2:0] want = oneshot_ok | bg_ok;
  wire done = (state_q == HKM_CONVERT) && i_conv_done;

  // Register writes
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_en_q <= REG_RESET;
      delta_cfg_q <= REG_RESET;
      strobe_q <= REG_RESET; // background off after reset
      thresh_q <= REG_RESET;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADDR_PWR_IRQ_EN: irq_en_q <= i_reg_wdata;
        ADDR_DELTA_CFG: delta_cfg_q <= i_reg_wdata;
        ADDR_STROBE_PERIOD: strobe_q <= i_reg_wdata;
        ADDR_BATT_THRESH: thresh_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Start bits: set by software, cleared when the converter takes the request
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_start && i_reg_wdata[i]) begin
          start_q[i] <= 1'b1;
        end else if (state_q == HKM_IDLE && |want && pick(want) == 2'(i) && start_q[i] && !sleeping) begin
          start_q[i] <= 1'b0;
        end
      end
    end
  end

  // Background tick divider
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
      tick_div_q <= 3'h0;
    end else begin
      tick_q <= 1'b0;
      if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= '0;
        tick_q <= 1'b1;
        tick_div_q <= tick_div_q + 3'h1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  // Background requests stay pending until served or until their interval is set to off
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bg_pend_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (interval_of(strobe_q, i) == PERIOD_OFF) begin
          bg_pend_q[i] <= 1'b0;
        end else if (period_hit(interval_of(strobe_q, i), tick_div_q, tick_q)) begin
          bg_pend_q[i] <= 1'b1;
        end else if (state_q == HKM_IDLE && |want && pick(want) == 2'(i) && !oneshot_ok[i]) begin
          bg_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= HKM_IDLE;
      chan_q <= HKM_CH_BATT;
      chan_oneshot_q <= 1'b0;
      o_conv_req <= 1'b0;
      o_conv_chan <= 2'h0;
      code_q <= 8'h00;
    end else begin
      unique case (state_q)
        HKM_IDLE: begin
          if (|want) begin
            chan_q <= hkm_chan_t'(pick(want));
            chan_oneshot_q <= oneshot_ok[pick(want)];
            o_conv_req <= 1'b1;
            o_conv_chan <= pick(want);
            state_q <= HKM_CONVERT;
          end
        end
        HKM_CONVERT: begin
          o_conv_req <= 1'b0;
          if (done) begin
            code_q <= i_conv_code;
            state_q <= HKM_DONE;
          end
        end
        HKM_DONE: state_q <= HKM_IDLE;
        default: state_q <= HKM_IDLE;
      endcase
    end
  end

  // Result evaluation in the DONE cycle
  wire [2:0] td = delta_cfg_q[DELTA_TEMP_LSB +: 3];
  wire [2:0] ed = delta_cfg_q[DELTA_EXT_LSB +: 3];
  wire in_done = (state_q == HKM_DONE);
  wire temp_event = in_done && chan_q == HKM_CH_TEMP &&
                    (chan_oneshot_q || delta_hit(td, abs_diff(code_q, temp_last_q)));
  wire ext_event = in_done && chan_q == HKM_CH_EXT &&
                   (chan_oneshot_q || delta_hit(ed, abs_diff(code_q, ext_last_q)));
  wire batt_event = in_done && chan_q == HKM_CH_BATT &&
                    (chan_oneshot_q || code_q < thresh_q);
  wire ext_flag_event = ext_event && !chan_oneshot_q;

  // Result and reference registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      temp_result_q <= REG_RESET;
      batt_result_q <= REG_RESET;
      ext_result_q <= REG_RESET;
      temp_last_q <= REG_RESET;
      ext_last_q <= REG_RESET;
    end else begin
      if (temp_event) begin
        temp_result_q <= code_q;
        temp_last_q <= code_q;
      end
      if (batt_event) begin
        batt_result_q <= code_q;
      end
      if (ext_event) begin
        ext_result_q <= code_q;
        ext_last_q <= code_q;
      end
    end
  end

  // Power flags: hardware set wins over software clear
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_battery_flag_q <= 1'b0;
      ext_change_flag_q <= 1'b0;
    end else begin
      if (batt_event) low_battery_flag_q <= 1'b1;
      else if (wr_flags && !i_reg_wdata[FLAG_BATT_BIT]) low_battery_flag_q <= 1'b0;
      if (ext_flag_event) ext_change_flag_q <= 1'b1;
      else if (wr_flags && !i_reg_wdata[FLAG_EXT_BIT]) ext_change_flag_q <= 1'b0;
    end
  end

  // Interrupt outputs
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_adc_irq <= 1'b0;
      o_power_management_irq <= 1'b0;
    end else begin
      o_adc_irq <= temp_event || ext_event;
      o_power_management_irq <=
        (low_battery_flag_q && irq_en_q[FLAG_BATT_BIT]) ||
        (ext_change_flag_q && irq_en_q[FLAG_EXT_BIT]);
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_TEMP_RESULT: o_reg_rdata <= temp_result_q;
        ADDR_MEAS_START: o_reg_rdata <= {5'h00, start_q};
        ADDR_BATT_RESULT: o_reg_rdata <= batt_result_q;
        ADDR_PWR_IRQ_EN: o_reg_rdata <= irq_en_q;
        ADDR_EXT_RESULT: o_reg_rdata <= ext_result_q;
        ADDR_DELTA_CFG: o_reg_rdata <= delta_cfg_q;
        ADDR_PWR_IRQ_FLAGS: o_reg_rdata <= {6'h00, ext_change_flag_q, low_battery_flag_q};
        ADDR_STROBE_PERIOD: o_reg_rdata <= strobe_q;
        ADDR_BATT_THRESH: o_reg_rdata <= thresh_q;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks: temperature and external results move only on their own events, the battery result only with its flag set
  a_temp_result_upd: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $changed(temp_result_q) |-> $past(temp_event))
    else $error("temperature result changed without interrupt");
  a_temp_irq_follow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    temp_event |=> o_adc_irq && temp_result_q == $past(code_q))
    else $error("temp interrupt missing");
  a_temp_last_ref: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    temp_event |=> temp_last_q == $past(code_q))
    else $error("temperature reference not updated");
  a_ext_result_upd: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $changed(ext_result_q) |-> $past(ext_event))
    else $error("external result changed without interrupt");
  a_ext_irq_follow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ext_event |=> o_adc_irq && ext_result_q == $past(code_q))
    else $error("external interrupt missing");
  a_adc_irq_pulse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_adc_irq |=> !o_adc_irq)
    else $error("converter interrupt longer than one cycle");
  a_batt_result_upd: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $changed(batt_result_q) |-> low_battery_flag_q)
    else $error("battery result changed without flag");

  // Flags are set only by hardware events
  a_batt_thresh_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    in_done && chan_q == HKM_CH_BATT && code_q < thresh_q |=> low_battery_flag_q)
    else $error("low battery not flagged");
  a_batt_flag_source: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(low_battery_flag_q) |-> $past(batt_event))
    else $error("low battery flag set without battery result");
  a_ext_flag_source: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(ext_change_flag_q) |-> $past(ext_flag_event))
    else $error("external flag set without background change");

  // Power-management interrupt trails the enabled flags by one cycle
  a_pm_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_power_management_irq |-> $past(low_battery_flag_q && irq_en_q[0] || ext_change_flag_q && irq_en_q[1]))
    else $error("power interrupt without enabled flag");
  a_pm_batt_follow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    low_battery_flag_q && irq_en_q[FLAG_BATT_BIT] |=> o_power_management_irq)
    else $error("enabled low battery flag without interrupt");
  a_pm_ext_follow: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ext_change_flag_q && irq_en_q[FLAG_EXT_BIT] |=> o_power_management_irq)
    else $error("enabled external flag without interrupt");

  // Mode gating and the request sequence
  a_sleep_no_batt: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_conv_req && o_conv_chan == HKM_CH_BATT |-> $past(!sleeping))
    else $error("battery conversion in sleep");
  a_bg_batt_full: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_conv_req && o_conv_chan == HKM_CH_BATT && !chan_oneshot_q |-> $past(full_power))
    else $error("background battery conversion outside full power");
  a_oneshot_awake: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_conv_req && chan_oneshot_q |-> $past(!sleeping))
    else $error("one-shot conversion in sleep");
  a_bg_mode_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_conv_req && !chan_oneshot_q |-> $past(full_power || sleeping))
    else $error("background conversion in battery-active mode");
  a_req_single: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_conv_req |=> !o_conv_req)
    else $error("request longer than one cycle");
  a_start_selfclear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_conv_req) && chan_oneshot_q |-> !start_q[o_conv_chan] || $past(wr_start))
    else $error("start bit not cleared");
  a_bg_off_idle: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    strobe_q == 8'h00 |=> bg_pend_q == 3'h0)
    else $error("background pending while disabled");

  // Delta decoding at the end points
  a_delta_off_quiet: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    in_done && chan_q == HKM_CH_EXT && !chan_oneshot_q && ed == DELTA_OFF |=> !ext_change_flag_q || $past(ext_change_flag_q))
    else $error("external flag set with delta off");
  a_delta_every_temp: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    in_done && chan_q == HKM_CH_TEMP && td == DELTA_EVERY |-> temp_event)
    else $error("temperature delta 111 did not interrupt");
  a_temp_delta_off: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    in_done && chan_q == HKM_CH_TEMP && !chan_oneshot_q && td == DELTA_OFF |-> !temp_event)
    else $error("temperature interrupt with delta off");

  // Main scenarios
  c_temp_oneshot: cover property (@(posedge i_mclk) temp_event && chan_oneshot_q);
  c_batt_low_bg: cover property (@(posedge i_mclk) batt_event && !chan_oneshot_q);
  c_ext_change: cover property (@(posedge i_mclk) ext_flag_event);
  c_pm_irq: cover property (@(posedge i_mclk) $rose(o_power_management_irq));
  c_bg_in_sleep: cover property (@(posedge i_mclk) o_conv_req && !chan_oneshot_q && sleeping);
endmodule

// ==== dv/hkm_adc_model.sv ====
/*
 * Behavioural stand-in for the shared housekeeping converter.
 * Assumes one-cycle request pulses and at most one conversion in flight.
 */
`timescale 1ns/1ps
module hkm_adc_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Request side
  input wire logic i_req,
  input wire logic i_slow,
  input wire logic [7:0] i_code,
  // Answer side
  output logic o_done,
  output logic [7:0] o_code
);
  int cnt;
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_code <= 8'hA5;
    end else begin
      o_done <= 1'b0;
      // Code means nothing without done, so it keeps toggling
      o_code <= ~o_code;
      if (i_req) begin
        cnt <= i_slow ? 7 : 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        o_done <= 1'b1;
        o_code <= i_code;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ==== dv/hkm_monitor_tb.sv ====
/*
 * Self-checking bench for the housekeeping converter monitor.
 * Assumes the converter stand-in hkm_adc_model and a shortened tick.
 */
`timescale 1ns/1ps
module hkm_monitor_tb;
  import hkm_pkg::*;
  logic i_mclk = 0, i_rstn = 0, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [7:0] reg_addr = 0, wdata = 0, nxt_code = 0, rdata, code;
  logic [1:0] mode = 0, chan, pipe = 0;
  logic req, done, adc_irq, pm_irq;
  logic [31:0] seed = 32'h0000E1D4;
  int failures = 0, total_checks = 0, cyc = 0, base = 40, h, order[$];
  int reqs[3] = '{0, 0, 0}, os[3] = '{0, 0, 0}, snap[3];
  int m_t = 0, m_b = 0, m_e = 0, m_f = 0, m_en = 0, m_d = 0, m_thr = 0, l_t = 0, l_e = 0, cur_ch = 0, cur_os = 0;
  logic [7:0] addrs[9] = '{ADDR_TEMP_RESULT, ADDR_MEAS_START, ADDR_BATT_RESULT, ADDR_PWR_IRQ_EN,
    ADDR_EXT_RESULT, ADDR_DELTA_CFG, ADDR_PWR_IRQ_FLAGS, ADDR_STROBE_PERIOD, ADDR_BATT_THRESH};

  hkm_monitor #(.TICK_CYCLES(4)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_power_mode(mode),
    .o_conv_req(req), .o_conv_chan(chan), .i_conv_done(done), .i_conv_code(code),
    .o_adc_irq(adc_irq), .o_power_management_irq(pm_irq));
  hkm_adc_model adc (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .i_slow(slow),
    .i_code(nxt_code), .o_done(done), .o_code(code));

  always #10 i_mclk = ~i_mclk;

  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[15:0]);
  endfunction

  function automatic int hit(int c, int l, int d);
    return d == 7 || (d != 0 && (c > l ? c - l : l - c) > d);
  endfunction

  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_mclk);
    reg_addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_mclk);
    reg_wr <= 1'b0;
    case (a)
      ADDR_MEAS_START: for (int i = 0; i < 3; i++) if (d[i]) os[i] = 1;
      ADDR_PWR_IRQ_EN: m_en = d;
      ADDR_DELTA_CFG: m_d = d;
      ADDR_PWR_IRQ_FLAGS: m_f = m_f & d;
      ADDR_BATT_THRESH: m_thr = d;
      default: ;
    endcase
  endtask

  task automatic rd(logic [7:0] a, int exp);
    @(posedge i_mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_mclk);
    reg_rd <= 1'b0;
    #1;
    if (exp >= 0) check($sformatf("reg_%h", a), rdata, 8'(exp));
  endtask

  task automatic regs();
    rd(ADDR_TEMP_RESULT, m_t);
    rd(ADDR_BATT_RESULT, m_b);
    rd(ADDR_EXT_RESULT, m_e);
    rd(ADDR_PWR_IRQ_FLAGS, m_f);
    rd(ADDR_MEAS_START, 0);
    check("pm_irq", 8'(pm_irq), 8'((m_f & m_en & 3) != 0));
  endtask

  task automatic wait_req(int n);
    int k = 0;
    while (reqs.sum() < n && k < 300) begin
      @(posedge i_mclk);
      k++;
    end
    check("req_seen", 8'(k < 300), 8'h01);
    repeat (12) @(posedge i_mclk);
  endtask

  // Reference model, updated on every request and every converter answer
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      complete_run();
    end else if (!i_rstn) begin
      pipe = 2'h0;
    end else begin
      check("adc_irq", 8'(adc_irq), 8'(pipe[1]));
      pipe = {pipe[0], 1'b0};
      if (req) begin
        reqs[chan]++;
        order.push_back(chan);
        cur_ch = chan;
        cur_os = os[chan];
        os[chan] = 0;
        nxt_code <= 8'(base + xs() % 8);
        slow <= 1'(xs() % 2);
      end
      if (done && cur_ch == HKM_CH_TEMP) begin
        h = cur_os || hit(code, l_t, m_d % 8);
        if (h) begin
          m_t = code;
          l_t = code;
        end
        pipe[0] = 1'(h);
      end
      if (done && cur_ch == HKM_CH_EXT) begin
        h = hit(code, l_e, m_d / 8 % 8);
        if (h && !cur_os) m_f = m_f | 2;
        if (h || cur_os) begin
          m_e = code;
          l_e = code;
        end
        pipe[0] = 1'(h || cur_os);
      end
      if (done && cur_ch == HKM_CH_BATT && (cur_os || code < m_thr)) begin
        m_f = m_f | 1;
        m_b = code;
      end
    end
  end

  initial begin
    repeat (6) @(posedge i_mclk);
    i_rstn <= 1'b1;
    repeat (40) @(posedge i_mclk);
    check("bg_off", 8'(reqs.sum()), 8'h00);
    foreach (addrs[i]) rd(addrs[i], 0);
    rd(8'h00, -1);
    wr(ADDR_PWR_IRQ_EN, 8'h03);
    wr(ADDR_MEAS_START, 8'h07);
    wait_req(3);
    check("order_len", 8'(order.size()), 8'h03);
    foreach (order[i]) check("order", 8'(order[i]), 8'(i));
    regs();
    for (int d = 0; d < 8; d++) begin
      base = 60 + 9 * d;
      wr(ADDR_DELTA_CFG, 8'(d * 9));
      wr(ADDR_STROBE_PERIOD, 8'h11);
      repeat (80) @(posedge i_mclk);
      wr(ADDR_STROBE_PERIOD, 8'h00);
      repeat (20) @(posedge i_mclk);
      regs();
      wr(ADDR_PWR_IRQ_FLAGS, 8'h00);
    end
    // Battery background with the flag masked first, then unmasked
    wr(ADDR_PWR_IRQ_EN, 8'h00);
    base = 100;
    wr(ADDR_BATT_THRESH, 8'h68);
    wr(ADDR_STROBE_PERIOD, 8'h04);
    repeat (80) @(posedge i_mclk);
    wr(ADDR_STROBE_PERIOD, 8'h00);
    repeat (20) @(posedge i_mclk);
    regs();
    wr(ADDR_PWR_IRQ_EN, 8'h03);
    repeat (3) @(posedge i_mclk);
    regs();
    for (int m = 1; m < 3; m++) begin
      mode <= 2'(m);
      snap = reqs;
      wr(ADDR_STROBE_PERIOD, 8'h15);
      repeat (80) @(posedge i_mclk);
      wr(ADDR_STROBE_PERIOD, 8'h00);
      repeat (20) @(posedge i_mclk);
      check("bg_batt", 8'(reqs[0] - snap[0]), 8'h00);
      check("bg_temp", 8'(reqs[1] > snap[1]), 8'(m - 1));
      check("bg_ext", 8'(reqs[2] > snap[2]), 8'(m - 1));
      if (m == 1) begin
        wr(ADDR_MEAS_START, 8'h07);
        wait_req(reqs.sum() + 3);
      end
      regs();
    end
    // A battery start in sleep must wait until the mode leaves sleep
    wr(ADDR_MEAS_START, 8'h01);
    snap = reqs;
    repeat (40) @(posedge i_mclk);
    check("sleep_batt", 8'(reqs[0] - snap[0]), 8'h00);
    mode <= HKM_FULL_POWER_MODE;
    wait_req(snap.sum() + 1);
    regs();
    complete_run();
  end
endmodule
